// ### ifcs_char_match.sv
// Compares one received character against the programmed Xon and Xoff codes.
// Assumes the codes are held stable by the channel elsewhere.
`timescale 1ns/1ps
`default_nettype none
module ifcs_char_match (
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic [7:0] i_xon_char,
    input wire logic [7:0] i_xoff_char,
    output logic o_is_xon,
    output logic o_is_xoff
);
    // Only a valid character that equals a programmed code counts
    assign o_is_xon = i_valid & (i_data == i_xon_char);
    assign o_is_xoff = i_valid & (i_data == i_xoff_char);
endmodule
`default_nettype wire

// ### ifcs_flow_emit.sv
// Holds pending Xon/Xoff transmit requests until the transmitter takes one.
// Assumes i_ack is a one-cycle pulse while o_req is high.
`timescale 1ns/1ps
`default_nettype none
module ifcs_flow_emit (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ifcs_pkg::ifcs_req_s i_req,
    input wire logic i_ack,
    input wire logic [7:0] i_xon_char,
    input wire logic [7:0] i_xoff_char,
    output logic o_req,
    output logic [7:0] o_char
);
    ifcs_pkg::ifcs_req_s pend;
    ifcs_pkg::ifcs_req_s next_pend;
    logic sent_xoff;
    // A newer request cancels the opposite one; a new request beats the ack
    assign sent_xoff = i_ack & pend.xoff;
    assign next_pend.xoff = i_req.xoff | (pend.xoff & ~i_req.xon & ~sent_xoff);
    assign next_pend.xon = i_req.xon | (pend.xon & ~i_req.xoff & ~(i_ack & ~pend.xoff));
    // Xoff goes first since it protects the local queue
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend <= '0;
            o_req <= 1'b0;
            o_char <= 8'h00;
        end else begin
            pend <= next_pend;
            o_req <= next_pend.xoff | next_pend.xon;
            o_char <= next_pend.xoff ? i_xoff_char : i_xon_char;
        end
    end
endmodule
`default_nettype wire

// ### ifcs_flow_strip.sv
// In-band Xon/Xoff flow control and recognized-character stripping, top level.
// Assumes the receiver offers one character per strobe with its address hit,
// and that the queue level and transmitter ack are synchronous to I_CORE_CLK.
//
// Overview of operation
// - Strip bit 7 drops recognized Xon/Xoff characters
// - Strip bit 6 drops recognized address characters
// - Stripped status lost unless block error mode
// - Stripping never changes interrupt generation
// - Flow field: host, auto tx, auto rx, both
// - Host mode: no automatic flow actions at all
// - Auto tx: received Xoff/Xon stop/restart transmitter
// - Auto rx: send Xoff at queue level 240
// - Auto rx: send Xon at level 128 or less
// - Nonzero flow field ignores command Xon/Xoff requests
// - Mask enables interrupt; status read clears it
// - Every flow character raises interrupt when enabled
// - Flow field never affects interrupt generation
// - Stripping applies regardless of other mode fields
`timescale 1ns/1ps
`default_nettype none
module ifcs_flow_strip (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic [2:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic I_RX_VALID,
    input wire ifcs_pkg::ifcs_rx_s I_RX_CHAR,
    input wire logic I_RX_ADDR_HIT,
    input wire logic I_BLOCK_ERR,
    input wire logic [7:0] I_XON_CHAR,
    input wire logic [7:0] I_XOFF_CHAR,
    input wire logic [8:0] I_Q_LEVEL,
    output logic O_Q_WR,
    output ifcs_pkg::ifcs_rx_s O_Q_CHAR,
    output logic O_STAT_ACC,
    output logic [3:0] O_STAT_BITS,
    output logic O_TX_ENABLE,
    output logic O_TX_REQ,
    output logic [7:0] O_TX_CHAR,
    input wire logic I_TX_ACK,
    output logic O_IRQ
);
    logic [7:0] mode;
    logic [1:0] mask;
    logic [1:0] sts;
    logic tx_stopped;
    ifcs_pkg::ifcs_rxfc_e rxfc;
    ifcs_pkg::ifcs_rxfc_e next_rxfc;
    logic is_xon;
    logic is_xoff;
    logic emit_req;
    logic [7:0] emit_char;

    // Address decode
    wire wr_mode = I_WR & (I_ADDR == ifcs_pkg::ADDR_MODE);
    wire wr_cmd = I_WR & (I_ADDR == ifcs_pkg::ADDR_CMD);
    wire wr_mask = I_WR & (I_ADDR == ifcs_pkg::ADDR_MASK);
    wire rd_stat = I_RD & (I_ADDR == ifcs_pkg::ADDR_STAT);

    // Mode fields
    wire [1:0] flow_mode = mode[ifcs_pkg::MODE_FLOW_LSB +: 2];
    wire host_mode = (flow_mode == ifcs_pkg::FLOW_HOST);
    wire auto_tx = mode[ifcs_pkg::MODE_AUTO_TX];
    wire auto_rx = mode[ifcs_pkg::MODE_AUTO_RX];
    wire strip_flow = mode[ifcs_pkg::MODE_STRIP_FLOW];
    wire strip_addr = mode[ifcs_pkg::MODE_STRIP_ADDR];

    ifcs_char_match u_match (
        .i_valid(I_RX_VALID),
        .i_data(I_RX_CHAR.data),
        .i_xon_char(I_XON_CHAR),
        .i_xoff_char(I_XOFF_CHAR),
        .o_is_xon(is_xon),
        .o_is_xoff(is_xoff)
    );

    // Strip decision looks only at the strip bits, never the flow field
    wire rx_flow = is_xon | is_xoff;
    wire rx_addr = I_RX_VALID & I_RX_ADDR_HIT;
    wire strip = (rx_flow & strip_flow) | (rx_addr & strip_addr);
    wire q_wr = I_RX_VALID & ~strip;
    wire stat_acc = I_RX_VALID & strip & I_BLOCK_ERR;

    // Receive path toward the queue
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_Q_WR <= 1'b0;
            O_Q_CHAR <= '0;
            O_STAT_ACC <= 1'b0;
            O_STAT_BITS <= 4'h0;
        end else begin
            O_Q_WR <= q_wr;
            O_Q_CHAR <= I_RX_CHAR;
            O_STAT_ACC <= stat_acc;
            O_STAT_BITS <= I_RX_CHAR.status;
        end
    end

    // Flow events set sticky bits whatever the strip or flow settings
    wire [1:0] set_bits = {is_xoff, is_xon};
    wire [1:0] next_sts = (rd_stat ? 2'h0 : sts) | set_bits;
    wire [1:0] next_mask = wr_mask ? I_WDATA[1:0] : mask;

    // Interrupt registers; the set wins over the read clear
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            sts <= ifcs_pkg::IRQ_RESET;
            mask <= ifcs_pkg::IRQ_RESET;
            O_IRQ <= 1'b0;
        end else begin
            sts <= next_sts;
            mask <= next_mask;
            O_IRQ <= |(next_sts & next_mask);
        end
    end

    // Mode register keeps reserved bits at zero
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            mode <= ifcs_pkg::MODE_RESET;
        end else if (wr_mode) begin
            mode <= I_WDATA & ifcs_pkg::MODE_WMASK;
        end
    end

    // Transmit gating follows received codes only in auto tx
    wire next_tx_stopped = ~auto_tx ? 1'b0 : is_xoff ? 1'b1 : is_xon ? 1'b0 : tx_stopped;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            tx_stopped <= 1'b0;
            O_TX_ENABLE <= 1'b1;
        end else begin
            tx_stopped <= next_tx_stopped;
            O_TX_ENABLE <= ~next_tx_stopped;
        end
    end

    // Receive-driven flow state; leaving auto rx while held frees it silently,
    // so software must send Xon itself if the far end was stopped
    wire lvl_high = (I_Q_LEVEL >= ifcs_pkg::LEVEL_XOFF);
    wire lvl_low = (I_Q_LEVEL <= ifcs_pkg::LEVEL_XON);
    ifcs_pkg::ifcs_req_s auto_req;
    ifcs_pkg::ifcs_req_s host_req;
    ifcs_pkg::ifcs_req_s all_req;

    always_comb begin
        next_rxfc = rxfc;
        auto_req = '0;
        case (rxfc)
            ifcs_pkg::RXFC_OPEN: begin
                if (auto_rx && lvl_high) begin
                    auto_req.xoff = 1'b1;
                    next_rxfc = ifcs_pkg::RXFC_HELD;
                end
            end
            ifcs_pkg::RXFC_HELD: begin
                if (!auto_rx) begin
                    next_rxfc = ifcs_pkg::RXFC_OPEN;
                end else if (lvl_low) begin
                    auto_req.xon = 1'b1;
                    next_rxfc = ifcs_pkg::RXFC_OPEN;
                end
            end
            default: begin
                next_rxfc = ifcs_pkg::RXFC_OPEN;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            rxfc <= ifcs_pkg::RXFC_OPEN;
        end else begin
            rxfc <= next_rxfc;
        end
    end

    // Command requests pass only in host mode
    assign host_req.xon = wr_cmd & host_mode & I_WDATA[ifcs_pkg::CMD_SEND_XON];
    assign host_req.xoff = wr_cmd & host_mode & I_WDATA[ifcs_pkg::CMD_SEND_XOFF];
    assign all_req = host_req | auto_req;

    ifcs_flow_emit u_emit (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SYS_RST),
        .i_req(all_req),
        .i_ack(I_TX_ACK),
        .i_xon_char(I_XON_CHAR),
        .i_xoff_char(I_XOFF_CHAR),
        .o_req(emit_req),
        .o_char(emit_char)
    );
    assign O_TX_REQ = emit_req;
    assign O_TX_CHAR = emit_char;

    // Read mux; unmapped addresses and the command register read zero
    wire [7:0] state_bits = {5'h00, emit_req, rxfc == ifcs_pkg::RXFC_HELD, tx_stopped};
    wire [7:0] rd_mux = (I_ADDR == ifcs_pkg::ADDR_MODE) ? mode :
                        (I_ADDR == ifcs_pkg::ADDR_MASK) ? {6'h00, mask} :
                        (I_ADDR == ifcs_pkg::ADDR_STAT) ? {6'h00, sts} :
                        (I_ADDR == ifcs_pkg::ADDR_STATE) ? state_bits : 8'h00;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= I_RD ? rd_mux : 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);

    property p_strip_flow;
        is_xoff | is_xon && strip_flow |=> !O_Q_WR;
    endproperty
    a_strip_flow: assert property (p_strip_flow) else $error("Stripped flow char queued");

    property p_keep_flow;
        rx_flow && !strip_flow && !(rx_addr && strip_addr) |=> O_Q_WR && O_Q_CHAR == $past(I_RX_CHAR);
    endproperty
    a_keep_flow: assert property (p_keep_flow) else $error("Flow char not queued");

    property p_strip_addr;
        rx_addr && strip_addr |=> !O_Q_WR;
    endproperty
    a_strip_addr: assert property (p_strip_addr) else $error("Stripped address char queued");

    property p_stat_acc;
        I_RX_VALID && strip |=> (O_STAT_ACC == $past(I_BLOCK_ERR)) && !O_Q_WR;
    endproperty
    a_stat_acc: assert property (p_stat_acc) else $error("Stripped status handling wrong");

    property p_irq_any;
        is_xoff |=> sts[ifcs_pkg::IRQ_XOFF] ##0 (O_IRQ == mask[ifcs_pkg::IRQ_XOFF] || O_IRQ);
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("Xoff did not set status");

    property p_irq_level;
        O_IRQ == |(sts & mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level mismatch");

    property p_rd_clear;
        rd_stat && !rx_flow |=> sts == 2'h0;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("Status read did not clear");

    property p_tx_gate;
        auto_tx && is_xoff |=> !O_TX_ENABLE ##0 tx_stopped;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("Xoff did not stop transmitter");

    property p_host_free;
        !auto_tx |=> O_TX_ENABLE;
    endproperty
    a_host_free: assert property (p_host_free) else $error("Transmitter gated outside auto tx");

    property p_auto_xoff;
        auto_rx && rxfc == ifcs_pkg::RXFC_OPEN && lvl_high && !I_TX_ACK
            |=> O_TX_REQ && O_TX_CHAR == $past(I_XOFF_CHAR);
    endproperty
    a_auto_xoff: assert property (p_auto_xoff) else $error("No Xoff at high level");

    property p_auto_xon;
        auto_rx && rxfc == ifcs_pkg::RXFC_HELD && lvl_low |=> rxfc == ifcs_pkg::RXFC_OPEN && O_TX_REQ;
    endproperty
    a_auto_xon: assert property (p_auto_xon) else $error("No Xon at low level");

    property p_cmd_ignored;
        wr_cmd && !host_mode && auto_req == '0 && !O_TX_REQ |=> !O_TX_REQ;
    endproperty
    a_cmd_ignored: assert property (p_cmd_ignored) else $error("Command sent flow char in auto mode");

    property p_reserved;
        mode[5:4] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved mode bits set");

    property p_match;
        is_xon |-> I_RX_CHAR.data == I_XON_CHAR;
    endproperty
    a_match: assert property (p_match) else $error("Xon recognized without match");

    // Kept characters must reach the queue unchanged, status included
    property p_keep_plain;
        I_RX_VALID && !strip |=> O_Q_WR && O_Q_CHAR == $past(I_RX_CHAR);
    endproperty
    a_keep_plain: assert property (p_keep_plain) else $error("Kept char not queued");

    property p_stat_bits;
        O_STAT_ACC |-> O_STAT_BITS == $past(I_RX_CHAR.status);
    endproperty
    a_stat_bits: assert property (p_stat_bits) else $error("Accumulated status wrong");

    property p_mode_read;
        I_RD && I_ADDR == ifcs_pkg::ADDR_MODE |=> O_RDATA[5:4] == 2'b00;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("Reserved mode bits read back");

    property p_irq_clear;
        rd_stat && !rx_flow |=> !O_IRQ;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("Interrupt stayed after read");

    property p_xon_irq;
        is_xon |=> sts[ifcs_pkg::IRQ_XON];
    endproperty
    a_xon_irq: assert property (p_xon_irq) else $error("Xon did not set status");

    property p_tx_restart;
        auto_tx && is_xon && !is_xoff |=> O_TX_ENABLE && !tx_stopped;
    endproperty
    a_tx_restart: assert property (p_tx_restart) else $error("Xon did not restart transmitter");

    property p_host_cmd;
        wr_cmd && host_mode && I_WDATA[ifcs_pkg::CMD_SEND_XON] |=> O_TX_REQ;
    endproperty
    a_host_cmd: assert property (p_host_cmd) else $error("Host command not sent");

    property p_host_quiet;
        host_mode && !wr_cmd && !O_TX_REQ |=> !O_TX_REQ;
    endproperty
    a_host_quiet: assert property (p_host_quiet) else $error("Automatic send in host mode");

    property p_open_quiet;
        auto_rx && rxfc == ifcs_pkg::RXFC_OPEN && !lvl_high && !O_TX_REQ |=> !O_TX_REQ;
    endproperty
    a_open_quiet: assert property (p_open_quiet) else $error("Xoff below high level");

    property p_held_quiet;
        auto_rx && rxfc == ifcs_pkg::RXFC_HELD && !lvl_low && !O_TX_REQ
            |=> !O_TX_REQ && rxfc == ifcs_pkg::RXFC_HELD;
    endproperty
    a_held_quiet: assert property (p_held_quiet) else $error("Xon above low level");

    c_strip: cover property (I_RX_VALID && strip && I_BLOCK_ERR);
    c_auto_cycle: cover property (rxfc == ifcs_pkg::RXFC_HELD ##[1:600] rxfc == ifcs_pkg::RXFC_OPEN);
    c_irq_clear: cover property (O_IRQ ##1 rd_stat ##1 !O_IRQ);
    c_tx_stop: cover property (auto_tx && is_xoff ##1 !O_TX_ENABLE);
    c_host_send: cover property (wr_cmd && host_mode ##1 O_TX_REQ);
endmodule
`default_nettype wire

// ### ifcs_flow_strip_tb.sv
// Self-checking bench for the flow-control and strip block.
// Assumes the remote model acks every emitted flow character.
`timescale 1ns/1ps
`default_nettype none
module ifcs_flow_strip_tb;
    localparam logic [7:0] XON = 8'h11;
    localparam logic [7:0] XOFF = 8'h13;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rx_valid = 1'b0, hit = 1'b0, blk = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, tx_char, last, sent, s0, m;
    logic [7:0] xon_code = XON;
    logic [8:0] level = 9'h000;
    ifcs_pkg::ifcs_rx_s rx_char = '0, q_char;
    logic q_wr, stat_acc, tx_en, tx_req, tx_ack, irq;
    logic [3:0] stat_bits, delay = 4'h0;
    logic [31:0] seed = 32'hf50d699c, r;
    int errors = 0, tests_run = 0;

    ifcs_flow_strip ifcs_flow_strip_inst (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_VALID(rx_valid),
        .I_RX_CHAR(rx_char), .I_RX_ADDR_HIT(hit), .I_BLOCK_ERR(blk), .I_XON_CHAR(xon_code),
        .I_XOFF_CHAR(XOFF), .I_Q_LEVEL(level), .O_Q_WR(q_wr), .O_Q_CHAR(q_char),
        .O_STAT_ACC(stat_acc), .O_STAT_BITS(stat_bits), .O_TX_ENABLE(tx_en), .O_TX_REQ(tx_req),
        .O_TX_CHAR(tx_char), .I_TX_ACK(tx_ack), .O_IRQ(irq));
    ifcs_remote_model ifcs_remote_model_inst (.i_clk(clk), .i_rst(rst), .i_tx_req(tx_req),
        .i_tx_char(tx_char), .i_delay(delay), .o_tx_ack(tx_ack), .o_last(last), .o_sent(sent));

    // Clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data is only looked at in the single cycle after the strobe
    task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, {4'h0, e}, {4'h0, rdata});
    endtask

    // One received character, then its queue and status outcome
    task automatic send(input logic [7:0] d, input logic h, input logic [7:0] md);
        logic [31:0] x;
        logic keep;
        logic b;
        x = rnd();
        b = x[0];
        keep = !((((d == XON) || (d == XOFF)) && md[7]) || (h && md[6]));
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_char <= {x[7:4], d};
        hit <= h;
        blk <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        #1 chk("q_wr", {11'h0, keep}, {11'h0, q_wr});
        chk("stat_acc", {11'h0, !keep && b}, {11'h0, stat_acc});
        chk("stat_bits", {8'h0, x[7:4]}, {8'h0, stat_bits});
        if (keep)
            chk("q_char", {x[7:4], d}, q_char);
    endtask

    task automatic finish_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog far beyond the several hundred cycles the tests need
    initial begin
        #(25 * 20000);
        errors++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk("mode", ifcs_pkg::ADDR_MODE, 8'h00);
        rd_chk("state", ifcs_pkg::ADDR_STATE, 8'h00);
        rd_chk("unmapped", 3'h7, 8'h00);
        chk("tx_en", 12'h1, {11'h0, tx_en});
        reg_wr(ifcs_pkg::ADDR_MODE, 8'hff);
        rd_chk("mode", ifcs_pkg::ADDR_MODE, 8'hcf);
        // Random strip and flow settings; status must not care about either
        for (int i = 0; i < 64; i++) begin
            r = rnd();
            m = {r[7:6], 2'b00, r[3:0]};
            reg_wr(ifcs_pkg::ADDR_MODE, m);
            send(r[9:8] == 2'd0 ? XON : r[9:8] == 2'd1 ? XOFF : {1'b1, r[22:16]}, r[10], m);
            rd_chk("status", ifcs_pkg::ADDR_STAT, {6'h0, r[9:8] == 2'd1, r[9:8] == 2'd0});
        end
        // Automatic transmit gating, and none in host mode
        reg_wr(ifcs_pkg::ADDR_MODE, 8'h04);
        send(XOFF, 1'b0, 8'h04);
        chk("tx_en", 12'h0, {11'h0, tx_en});
        send(XON, 1'b0, 8'h04);
        chk("tx_en", 12'h1, {11'h0, tx_en});
        reg_wr(ifcs_pkg::ADDR_MODE, 8'h00);
        send(XOFF, 1'b0, 8'h00);
        chk("tx_en", 12'h1, {11'h0, tx_en});
        rd_chk("status", ifcs_pkg::ADDR_STAT, 8'h03);
        // Masked interrupt, then read clear
        reg_wr(ifcs_pkg::ADDR_MASK, 8'h02);
        rd_chk("mask", ifcs_pkg::ADDR_MASK, 8'h02);
        send(XON, 1'b0, 8'h00);
        chk("irq", 12'h0, {11'h0, irq});
        send(XOFF, 1'b0, 8'h00);
        chk("irq", 12'h1, {11'h0, irq});
        rd_chk("status", ifcs_pkg::ADDR_STAT, 8'h03);
        chk("irq", 12'h0, {11'h0, irq});
        // Host commands are sent in host mode only
        rd_chk("cmd", ifcs_pkg::ADDR_CMD, 8'h00);
        s0 = sent;
        reg_wr(ifcs_pkg::ADDR_CMD, 8'h01);
        idle(30);
        chk("sent", {4'h0, s0 + 8'h01}, {4'h0, sent});
        chk("last", {4'h0, XON}, {4'h0, last});
        for (int f = 1; f < 4; f++) begin
            reg_wr(ifcs_pkg::ADDR_MODE, {4'h0, 2'(f), 2'b00});
            reg_wr(ifcs_pkg::ADDR_CMD, 8'h03);
            idle(30);
            chk("sent", {4'h0, s0 + 8'h01}, {4'h0, sent});
        end
        // Receive-driven flow with a slow or prompt remote
        reg_wr(ifcs_pkg::ADDR_MODE, 8'h08);
        r = rnd();
        delay <= r[3:0];
        level <= 9'd239;
        idle(4);
        chk("tx_req", 12'h0, {11'h0, tx_req});
        level <= 9'd240;
        idle(1);
        chk("tx_req", 12'h1, {11'h0, tx_req});
        chk("tx_char", {4'h0, XOFF}, {4'h0, tx_char});
        idle(30);
        chk("sent", {4'h0, s0 + 8'h02}, {4'h0, sent});
        rd_chk("state", ifcs_pkg::ADDR_STATE, 8'h02);
        level <= 9'd129;
        idle(30);
        chk("sent", {4'h0, s0 + 8'h02}, {4'h0, sent});
        level <= 9'd128;
        idle(30);
        chk("sent", {4'h0, s0 + 8'h03}, {4'h0, sent});
        chk("last", {4'h0, XON}, {4'h0, last});
        // Recognition follows the programmed code, not a fixed value
        xon_code <= 8'h5a;
        send(XON, 1'b0, 8'h08);
        rd_chk("status", ifcs_pkg::ADDR_STAT, 8'h00);
        send(8'h5a, 1'b0, 8'h08);
        rd_chk("status", ifcs_pkg::ADDR_STAT, 8'h01);
        finish_test();
    end
endmodule
`default_nettype wire

// ### ifcs_pkg.sv
// Constants and types for the in-band flow-control and strip block.
// Assumes one 40 MHz core clock; nothing here is timing critical.
package ifcs_pkg;
    // Register indexes on the 3-bit register port
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_CMD = 3'h1;
    localparam logic [2:0] ADDR_MASK = 3'h2;
    localparam logic [2:0] ADDR_STAT = 3'h3;
    localparam logic [2:0] ADDR_STATE = 3'h4;
    // Mode register fields
    localparam int MODE_STRIP_FLOW = 7;
    localparam int MODE_STRIP_ADDR = 6;
    localparam int MODE_AUTO_RX = 3;
    localparam int MODE_AUTO_TX = 2;
    localparam int MODE_FLOW_LSB = 2;
    localparam logic [7:0] MODE_WMASK = 8'hcf;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Command register bits
    localparam int CMD_SEND_XON = 0;
    localparam int CMD_SEND_XOFF = 1;
    // Interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_XON = 0;
    localparam int IRQ_XOFF = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // State register bits
    localparam int ST_TX_STOP = 0;
    localparam int ST_HELD = 1;
    localparam int ST_TX_REQ = 2;
    // Receive queue fill thresholds
    localparam int LEVEL_W = 9;
    localparam logic [8:0] LEVEL_XOFF = 9'h0f0;
    localparam logic [8:0] LEVEL_XON = 9'h080;
    typedef enum logic [1:0] {
        FLOW_HOST = 2'b00,
        FLOW_AUTO_TX = 2'b01,
        FLOW_AUTO_RX = 2'b10,
        FLOW_AUTO_BOTH = 2'b11
    } ifcs_flow_e;
    typedef enum logic {
        RXFC_OPEN = 1'b0,
        RXFC_HELD = 1'b1
    } ifcs_rxfc_e;
    typedef struct packed {
        logic [3:0] status;
        logic [7:0] data;
    } ifcs_rx_s;
    typedef struct packed {
        logic xoff;
        logic xon;
    } ifcs_req_s;
endpackage

// ### ifcs_remote_model.sv
// Model of the line-side transmitter and the remote station it feeds.
// Assumes O_TX_REQ stands until the cycle after the ack pulse.
`timescale 1ns/1ps
`default_nettype none
module ifcs_remote_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tx_req,
    input wire logic [7:0] i_tx_char,
    input wire logic [3:0] i_delay,
    output logic o_tx_ack,
    output logic [7:0] o_last,
    output logic [7:0] o_sent
);
    logic [3:0] cnt;
    // Ack after a chosen delay; skip the edge after an ack, when the request is still dropping
    always_ff @(posedge i_clk) begin
        o_tx_ack <= 1'b0;
        if (i_rst) begin
            cnt <= 4'h0;
            o_sent <= 8'h00;
            o_last <= 8'h00;
        end else if (o_tx_ack) begin
            cnt <= 4'h0;
        end else if (i_tx_req) begin
            if (cnt == i_delay) begin
                o_tx_ack <= 1'b1;
                o_last <= i_tx_char;
                o_sent <= o_sent + 8'h01;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire
